/* File: core/kms_scan_port.sv */
// The implementer's own choice: the plain strobed port.
module kms_scan_port (
    input wire logic clk,
    input wire logic rst,
    input wire logic [kms_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [kms_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [kms_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [kms_pkg::COLS-1:0] column_sense_line,
    output logic [kms_pkg::ROWS-1:0] row_drive_line_out,
    output logic [kms_pkg::ROWS-1:0] row_drive_line_oe,
    input wire logic bus_clk_stopped,
    output logic scan_runtime_irq,
    output logic scan_wake_irq,
    output logic clk_request
);
    import kms_pkg::*;

    logic [SEL_W-1:0] select_ff;
    logic predrive_ff;
    logic [COLS-1:0] col_meta_ff;
    logic [COLS-1:0] col_sync_ff;
    logic [COLS-1:0] col_prev_ff;
    logic [COLS-1:0] edge_flags_ff;
    logic [COLS-1:0] nxt_edge_flags;
    logic [COLS-1:0] irq_mask_ff;
    logic stop_meta_ff;
    logic stop_sync_ff;
    logic runtime_ff;
    logic lockout_ff;
    logic wake_ff;
    logic clk_req_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic [SEL_ROW_W-1:0] row_prev_ff;

    logic scan_on;
    logic polarity;
    logic drive_all;
    logic [SEL_ROW_W-1:0] row_sel;
    logic [COLS-1:0] col_fall;
    logic [COLS-1:0] col_clear;
    logic [COLS-1:0] col_irq;
    logic any_col_irq;
    logic cols_all_high;
    logic row_changed;
    logic wr_select;
    logic wr_flags;
    logic wr_mask;
    logic wr_ext;
    logic [ROWS-1:0] row_want;

    assign scan_on = ~select_ff[SEL_DISABLE_BIT];
    assign polarity = select_ff[SEL_POLARITY_BIT];
    assign drive_all = select_ff[SEL_ALL_BIT];
    assign row_sel = select_ff[SEL_ROW_LSB +: SEL_ROW_W];

    assign wr_select = reg_wr && (reg_addr == OFF_ROW_SELECT);
    assign wr_flags = reg_wr && (reg_addr == OFF_EDGE_FLAGS);
    assign wr_mask = reg_wr && (reg_addr == OFF_IRQ_MASK);
    assign wr_ext = reg_wr && (reg_addr == OFF_EXT_CTRL);

    // Register writes.

    always_ff @(posedge clk) begin
        if (rst) begin
            select_ff <= SEL_RESET;
        end else if (wr_select) begin
            select_ff <= reg_wdata[SEL_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_ff <= MASK_RESET;
        end else if (wr_mask) begin
            irq_mask_ff <= reg_wdata[COLS-1:0];
        end
    end

    // Software must disable scanning before changing this bit, so the pad
    // type and the drive mode never disagree while rows are driven.
    always_ff @(posedge clk) begin
        if (rst) begin
            predrive_ff <= EXT_PREDRIVE_RESET;
        end else if (wr_ext) begin
            predrive_ff <= reg_wdata[EXT_PREDRIVE_BIT];
        end
    end

    // Row decode.

    // Out-of-range selects and drive-all fall through to the idle level.
    generate
        for (genvar i = 0; i < ROWS; i++) begin : g_row
            always_comb begin
                if (!drive_all && row_sel == SEL_ROW_W'(i)) begin
                    row_want[i] = polarity;
                end else begin
                    row_want[i] = ~polarity;
                end
            end

            kms_predrive u_pd (
                .clk(clk),
                .rst(rst),
                .scan_on(scan_on),
                .predrive_en(predrive_ff),
                .level_want(row_want[i]),
                .line_out(row_drive_line_out[i]),
                .line_oe(row_drive_line_oe[i])
            );
        end
    endgenerate

    // Column inputs.

    // The pins are asynchronous to clk; only the second stage feeds logic.
    always_ff @(posedge clk) begin
        if (rst) begin
            col_meta_ff <= '0;
            col_sync_ff <= '0;
        end else begin
            col_meta_ff <= column_sense_line;
            col_sync_ff <= col_meta_ff;
        end
    end

    // The history stage resets to zero so that a high column at reset
    // release is not mistaken for a falling edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            col_prev_ff <= '0;
        end else begin
            col_prev_ff <= col_sync_ff;
        end
    end

    assign col_fall = col_prev_ff & ~col_sync_ff;
    assign col_clear = wr_flags ? reg_wdata[COLS-1:0] : '0;
    assign cols_all_high = &col_sync_ff;

    // Edge flags.

    always_comb begin
        nxt_edge_flags = (edge_flags_ff & ~col_clear) | col_fall;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            edge_flags_ff <= FLAGS_RESET;
        end else begin
            edge_flags_ff <= nxt_edge_flags;
        end
    end

    assign col_irq = edge_flags_ff & irq_mask_ff;
    assign any_col_irq = |col_irq;

    // Runtime interrupt.

    always_ff @(posedge clk) begin
        if (rst) begin
            row_prev_ff <= '0;
        end else begin
            row_prev_ff <= row_sel;
        end
    end

    assign row_changed = (row_prev_ff != row_sel);

    // Once the interrupt has fired, a lockout holds it off until the matrix
    // settles or the scan moves to another row; this keeps one held key from
    // producing a storm of interrupts while firmware works through the rows.
    always_ff @(posedge clk) begin
        if (rst) begin
            lockout_ff <= 1'b0;
        end else if (cols_all_high || row_changed) begin
            lockout_ff <= 1'b0;
        end else if (runtime_ff) begin
            lockout_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            runtime_ff <= 1'b0;
        end else begin
            runtime_ff <= any_col_irq && (runtime_ff || !lockout_ff);
        end
    end

    // Wake interrupt.

    always_ff @(posedge clk) begin
        if (rst) begin
            stop_meta_ff <= 1'b0;
            stop_sync_ff <= 1'b0;
        end else begin
            stop_meta_ff <= bus_clk_stopped;
            stop_sync_ff <= stop_meta_ff;
        end
    end

    // While the bus clock is stopped the wake line latches and holds until
    // the restart; with the clock running it simply follows the column OR.
    always_ff @(posedge clk) begin
        if (rst) begin
            wake_ff <= 1'b0;
        end else if (stop_sync_ff) begin
            wake_ff <= wake_ff || any_col_irq;
        end else begin
            wake_ff <= any_col_irq;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            clk_req_ff <= 1'b0;
        end else if (stop_sync_ff) begin
            clk_req_ff <= clk_req_ff || any_col_irq;
        end else begin
            clk_req_ff <= 1'b0;
        end
    end

    // Read path.

    always_comb begin
        nxt_rdata = READ_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                OFF_ROW_SELECT: nxt_rdata[SEL_W-1:0] = select_ff;
                OFF_COL_LEVELS: nxt_rdata[COLS-1:0] = col_sync_ff;
                OFF_EDGE_FLAGS: nxt_rdata[COLS-1:0] = edge_flags_ff;
                OFF_IRQ_MASK: nxt_rdata[COLS-1:0] = irq_mask_ff;
                OFF_EXT_CTRL: nxt_rdata[EXT_PREDRIVE_BIT] = predrive_ff;
                default: nxt_rdata = READ_ZERO;
            endcase
        end
    end

    // Read data stand for exactly one cycle and are zero otherwise.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_ff <= READ_ZERO;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;
    assign scan_runtime_irq = runtime_ff;
    assign scan_wake_irq = wake_ff;
    assign clk_request = clk_req_ff;

endmodule

/* File: core/kms_pkg.sv */
package kms_pkg;

    localparam int ROWS = 18;
    localparam int COLS = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] OFF_ROW_SELECT = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_COL_LEVELS = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_EDGE_FLAGS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_EXT_CTRL = 8'h14;

    localparam int SEL_POLARITY_BIT = 7;
    localparam int SEL_DISABLE_BIT = 6;
    localparam int SEL_ALL_BIT = 5;
    localparam int SEL_ROW_LSB = 0;
    localparam int SEL_ROW_W = 5;
    localparam int SEL_W = 8;
    localparam logic [SEL_W-1:0] SEL_RESET = 8'h40;
    localparam logic [COLS-1:0] FLAGS_RESET = 8'h00;
    localparam logic [COLS-1:0] MASK_RESET = 8'h00;
    localparam int EXT_PREDRIVE_BIT = 0;
    localparam logic EXT_PREDRIVE_RESET = 1'b0;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    localparam int CLK_HZ = 100_000_000;
    localparam int PREDRIVE_REF_HZ = 48_000_000;
    localparam int PREDRIVE_REF_CYCLES = 2;
    // A least time, so the cycle count rounds up.
    localparam int PREDRIVE_CLKS =
        (PREDRIVE_REF_CYCLES * CLK_HZ + PREDRIVE_REF_HZ - 1) / PREDRIVE_REF_HZ;
    localparam int PD_CNT_W = 3;
    localparam logic [PD_CNT_W-1:0] PD_CNT_LAST = PD_CNT_W'(PREDRIVE_CLKS - 1);

    typedef enum logic [1:0] {
        PD_LOW = 2'b00,
        PD_BOOST = 2'b01,
        PD_FLOAT = 2'b11,
        PD_HIGH = 2'b10
    } kms_pd_state_type;

endpackage

/* File: core/kms_predrive.sv */
module kms_predrive (
    input wire logic clk,
    input wire logic rst,
    input wire logic scan_on,
    input wire logic predrive_en,
    input wire logic level_want,
    output logic line_out,
    output logic line_oe
);
    import kms_pkg::*;

    kms_pd_state_type state_ff;
    kms_pd_state_type nxt_state;
    logic [PD_CNT_W-1:0] cnt_ff;
    logic out_ff;
    logic oe_ff;

    always_comb begin
        nxt_state = state_ff;
        if (!scan_on || !level_want) begin
            nxt_state = PD_LOW;
        end else if (!predrive_en) begin
            nxt_state = PD_HIGH;
        end else begin
            unique case (state_ff)
                PD_LOW, PD_HIGH: nxt_state = PD_BOOST;
                PD_BOOST: nxt_state = (cnt_ff == PD_CNT_LAST) ? PD_FLOAT : PD_BOOST;
                PD_FLOAT: nxt_state = PD_FLOAT;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff <= PD_LOW;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk) begin
        if (rst || nxt_state != PD_BOOST || state_ff != PD_BOOST) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + 1'b1;
        end
    end

    // The pin follows the next state so a line changes one cycle after its want.
    always_ff @(posedge clk) begin
        if (rst) begin
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else if (!scan_on) begin
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            out_ff <= level_want;
            oe_ff <= (nxt_state != PD_FLOAT);
        end
    end

    assign line_out = out_ff;
    assign line_oe = oe_ff;

endmodule

/* File: sim/kms_matrix.sv */
module kms_matrix (
    input wire logic [kms_pkg::ROWS-1:0] row_out,
    input wire logic [kms_pkg::ROWS-1:0] row_oe,
    input wire logic [kms_pkg::ROWS*kms_pkg::COLS-1:0] key_down,
    output logic [kms_pkg::COLS-1:0] column_line
);
    timeunit 1ns;
    timeprecision 1ns;
    import kms_pkg::*;
    // Columns have pull-ups, so a closed key pulls low only if its row is actively driven low.
    always_comb begin
        column_line = '1;
        for (int k = 0; k < ROWS * COLS; k++) begin
            if (key_down[k] && row_oe[k / COLS] && !row_out[k / COLS]) begin
                column_line[k % COLS] = 1'b0;
            end
        end
    end
endmodule

/* File: sim/kms_scan_port_chk.sv */
module kms_scan_port_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [kms_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [kms_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [kms_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [kms_pkg::COLS-1:0] column_sense_line,
    input wire logic [kms_pkg::ROWS-1:0] row_drive_line_out,
    input wire logic [kms_pkg::ROWS-1:0] row_drive_line_oe,
    input wire logic bus_clk_stopped,
    input wire logic scan_runtime_irq,
    input wire logic scan_wake_irq,
    input wire logic clk_request
);
    timeunit 1ns;
    timeprecision 1ns;
    import kms_pkg::*;
    logic off_ff;
    logic [COLS-1:0] mask_ff;
    logic ext_ff;
    // Shadows of the settings, taken at the same edge as the design's own registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            off_ff <= SEL_RESET[SEL_DISABLE_BIT];
            mask_ff <= MASK_RESET;
            ext_ff <= EXT_PREDRIVE_RESET;
        end else if (reg_wr && reg_addr == OFF_ROW_SELECT) begin
            off_ff <= reg_wdata[SEL_DISABLE_BIT];
        end else if (reg_wr && reg_addr == OFF_IRQ_MASK) begin
            mask_ff <= reg_wdata[COLS-1:0];
        end else if (reg_wr && reg_addr == OFF_EXT_CTRL) begin
            ext_ff <= reg_wdata[EXT_PREDRIVE_BIT];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence clk_running;
        !bus_clk_stopped [*4];
    endsequence
    sequence boost_then_float;
        row_drive_line_oe[0] [*5] ##1 !row_drive_line_oe[0];
    endsequence
    a_disabled_rows_off: assert property (
        off_ff && $past(off_ff) |-> row_drive_line_oe == '0
    ) else $error("Row buffers on while scanning is off.");
    a_predrive_boost: assert property (
        ext_ff && $rose(row_drive_line_out[0]) |-> boost_then_float
    ) else $error("Rising row not boosted for the set time.");
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == READ_ZERO
    ) else $error("Read data not zero outside a read.");
    a_read_upper_zero: assert property (
        reg_rd |=> reg_rdata[DATA_W-1:COLS] == '0
    ) else $error("Upper read bits not zero.");
    a_mask_readback: assert property (
        reg_rd && reg_addr == OFF_IRQ_MASK |=> reg_rdata[COLS-1:0] == mask_ff
    ) else $error("Mask read back wrong.");
    a_masked_quiet: assert property (
        mask_ff == '0 && $past(mask_ff) == '0 |-> !scan_runtime_irq
    ) else $error("Runtime interrupt with all columns masked.");
    a_clkreq_idle: assert property (
        clk_running |-> !clk_request
    ) else $error("Clock request while the clock runs.");
    a_wake_holds: assert property (
        bus_clk_stopped [*3] ##0 scan_wake_irq |=> scan_wake_irq
    ) else $error("Wake interrupt dropped while clock stopped.");
endmodule

bind kms_scan_port kms_scan_port_chk u_kms_scan_port_chk (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .column_sense_line,
    .row_drive_line_out, .row_drive_line_oe, .bus_clk_stopped, .scan_runtime_irq,
    .scan_wake_irq, .clk_request
);

/* File: sim/kms_scan_port_test.sv */
module kms_scan_port_test;
    timeunit 1ns;
    timeprecision 1ns;
    import kms_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic bus_clk_stopped = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic [ROWS*COLS-1:0] key_down = '0;
    logic [DATA_W-1:0] reg_rdata;
    logic [COLS-1:0] column_sense_line;
    logic [ROWS-1:0] row_out;
    logic [ROWS-1:0] row_oe;
    logic scan_runtime_irq;
    logic scan_wake_irq;
    logic clk_request;
    logic [SEL_W-1:0] sel;
    logic [ROWS-1:0] want;
    logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h10, 5'h11, 5'h12, 5'h1f};
    int fails = 0;
    int check_count = 0;
    wire [2:0] irqs = {scan_wake_irq, scan_runtime_irq, clk_request};
    always #5 clk = ~clk;
    kms_scan_port u_kms_scan_port (
        .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .column_sense_line,
        .row_drive_line_out(row_out), .row_drive_line_oe(row_oe), .bus_clk_stopped,
        .scan_runtime_irq, .scan_wake_irq, .clk_request
    );
    kms_matrix u_kms_matrix (.row_out, .row_oe, .key_down, .column_line(column_sense_line));
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        // Reserved upper bits go out as ones to show that they are ignored.
        reg_wdata <= {24'hff_ffff, d};
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, 32'(e));
    endtask
    task automatic pause(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rd(OFF_ROW_SELECT, 8'h40);
        rd(OFF_EDGE_FLAGS, 8'h00);
        rd(OFF_IRQ_MASK, 8'h00);
        rd(OFF_EXT_CTRL, 8'h00);
        rd(8'h18, 8'h00);
        chk(32'(row_oe), 32'h0);
        for (int i = 0; i < 24; i++) begin
            sel = {1'(i / 12), 1'b0, 1'(i / 6 % 2), codes[i % 6]};
            want = '1;
            if (!sel[SEL_ALL_BIT] && sel[4:0] < 5'h12) begin
                want[sel[4:0]] = 1'b0;
            end
            want = sel[SEL_POLARITY_BIT] ? ~want : want;
            wr(OFF_ROW_SELECT, sel);
            pause(2);
            chk(32'(row_out), 32'(want));
            chk(32'(row_oe), 32'h0003_ffff);
            rd(OFF_ROW_SELECT, sel);
        end
        wr(OFF_ROW_SELECT, 8'he3);
        pause(2);
        chk(32'(row_oe), 32'h0);
        wr(OFF_IRQ_MASK, 8'hff);
        rd(OFF_IRQ_MASK, 8'hff);
        wr(OFF_IRQ_MASK, 8'h00);
        wr(OFF_ROW_SELECT, 8'h03);
        key_down[3 * COLS + 2] <= 1'b1;
        pause(8);
        rd(OFF_COL_LEVELS, 8'hfb);
        rd(OFF_EDGE_FLAGS, 8'h04);
        chk(32'(irqs), 32'h0);
        wr(OFF_IRQ_MASK, 8'h04);
        pause(2);
        chk(32'(irqs), 32'h6);
        wr(OFF_EDGE_FLAGS, 8'hfb);
        rd(OFF_EDGE_FLAGS, 8'h04);
        wr(OFF_EDGE_FLAGS, 8'h04);
        rd(OFF_EDGE_FLAGS, 8'h00);
        key_down[3 * COLS + 5] <= 1'b1;
        wr(OFF_IRQ_MASK, 8'h24);
        pause(8);
        chk(32'(irqs), 32'h4);
        key_down <= '0;
        pause(8);
        chk(32'(irqs), 32'h6);
        wr(OFF_EDGE_FLAGS, 8'hff);
        bus_clk_stopped <= 1'b1;
        key_down[3 * COLS + 2] <= 1'b1;
        pause(8);
        chk(32'(irqs & 3'h5), 32'h5);
        wr(OFF_EDGE_FLAGS, 8'hff);
        pause(2);
        chk(32'(irqs & 3'h5), 32'h5);
        @(posedge clk);
        bus_clk_stopped <= 1'b0;
        key_down <= '0;
        pause(6);
        chk(32'(irqs), 32'h0);
        wr(OFF_ROW_SELECT, 8'h40);
        wr(OFF_EXT_CTRL, 8'h01);
        rd(OFF_EXT_CTRL, 8'h01);
        wr(OFF_ROW_SELECT, 8'h00);
        pause(10);
        chk(32'(row_oe), 32'h1);
        wr(OFF_ROW_SELECT, 8'h01);
        pause(2);
        chk(32'(row_oe[0]), 32'h1);
        pause(8);
        chk(32'(row_oe), 32'h2);
        // A fall flagged in the very cycle of its clear must survive it.
        @(posedge clk);
        key_down[COLS + 3] <= 1'b1;
        @(posedge clk);
        wr(OFF_EDGE_FLAGS, 8'h08);
        rd(OFF_EDGE_FLAGS, 8'h08);
        wr(OFF_IRQ_MASK, 8'h08);
        pause(2);
        chk(32'(irqs), 32'h6);
        wr(OFF_IRQ_MASK, 8'h00);
        wr(OFF_IRQ_MASK, 8'h08);
        pause(2);
        chk(32'(irqs), 32'h4);
        // All rows low keep the column low, so only the row change lifts the lockout.
        wr(OFF_ROW_SELECT, 8'ha2);
        pause(3);
        chk(32'(irqs), 32'h6);
        end_sim();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_sim();
    end
endmodule
